// ==== srs_pin_model.sv ====
// far-side model: pull-ups on the open-drain pins, pull-down on the request line
`timescale 1ns/10ps
module srs_pin_model (
    input wire logic rst_oe_n_i,
    input wire logic rst_data_i,
    input wire logic m2_oe_n_i,
    input wire logic m2_data_i,
    input wire logic m3_oe_n_i,
    input wire logic m3_data_i,
    input wire logic req_en_i,
    input wire logic req_val_i,
    output logic rst_wire_o,
    output logic m2_wire_o,
    output logic m3_wire_o,
    output logic req_wire_o
);
    // released pins float up through the external resistors
    assign rst_wire_o = rst_oe_n_i ? 1'h1 : rst_data_i;
    assign m2_wire_o = m2_oe_n_i ? 1'h1 : m2_data_i;
    assign m3_wire_o = m3_oe_n_i ? 1'h1 : m3_data_i;
    // request line rests low unless the processor drives it
    assign req_wire_o = req_en_i ? req_val_i : 1'h0;
endmodule : srs_pin_model

// ==== srs_pkg.sv ====
// constants, types and timing figures of the supply reset supervisor
package srs_pkg;

    // core clock rate
    localparam int SRS_CLK_MHZ = 40;

    // width of the hold counter, enough for the longest hold choice
    localparam int SRS_CNT_W = 20;
    typedef logic [SRS_CNT_W-1:0] srs_cnt_t;

    // hold time choices in microseconds, one per delay-select code
    localparam int SRS_HOLD_TIME_US_0 = 1000;
    localparam int SRS_HOLD_TIME_US_1 = 2000;
    localparam int SRS_HOLD_TIME_US_2 = 4000;
    localparam int SRS_HOLD_TIME_US_3 = 8000;

    // hold times as core clock cycles (whole microseconds, so exact)
    localparam int SRS_HOLD_CYC_0 = SRS_HOLD_TIME_US_0 * SRS_CLK_MHZ;
    localparam int SRS_HOLD_CYC_1 = SRS_HOLD_TIME_US_1 * SRS_CLK_MHZ;
    localparam int SRS_HOLD_CYC_2 = SRS_HOLD_TIME_US_2 * SRS_CLK_MHZ;
    localparam int SRS_HOLD_CYC_3 = SRS_HOLD_TIME_US_3 * SRS_CLK_MHZ;

    // delay-select codes
    localparam logic [1:0] SRS_SEL_0 = 2'h0;
    localparam logic [1:0] SRS_SEL_1 = 2'h1;
    localparam logic [1:0] SRS_SEL_2 = 2'h2;

    // values after reset, and the last hold count
    localparam logic SRS_SYNC_RST = 1'h0;
    localparam logic SRS_PIN_LOW_RST = 1'h0;
    localparam logic SRS_RESET_ACTIVE_RST = 1'h1;
    localparam logic SRS_MON_RELEASE_RST = 1'h0;
    localparam srs_cnt_t SRS_CNT_RST = 20'h00000;
    localparam srs_cnt_t SRS_CNT_LAST = 20'h00001;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        SRS_ST_ACTIVE = 3'b001,
        SRS_ST_HOLD = 3'b010,
        SRS_ST_RUN = 3'b100
    } srs_state_t;

endpackage : srs_pkg

// ==== srs_supervisor.sv ====
// supply reset supervisor: reset hold sequencer and monitor indicators
`timescale 1ns/10ps

// What this block does
// - low supply forces the reset output active
// - power-up asserts reset until hold expires
// - two-bit select chooses hold for later cycles
// - manual request high forces reset active
// - reset held for hold time after request
// - monitor3 indicator follows comparator, no hold
// - monitor2 indicator follows comparator, no hold
module srs_supervisor #(
    parameter srs_pkg::srs_cnt_t HOLD_CYC_0 = srs_pkg::SRS_HOLD_CYC_0[19:0],
    parameter srs_pkg::srs_cnt_t HOLD_CYC_1 = srs_pkg::SRS_HOLD_CYC_1[19:0],
    parameter srs_pkg::srs_cnt_t HOLD_CYC_2 = srs_pkg::SRS_HOLD_CYC_2[19:0],
    parameter srs_pkg::srs_cnt_t HOLD_CYC_3 = srs_pkg::SRS_HOLD_CYC_3[19:0]
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic supply_ok_i,
    input wire logic manual_reset_request_i,
    input wire logic monitor2_input_i,
    input wire logic monitor3_input_i,
    input wire logic hold_select_lsb_i,
    input wire logic hold_select_msb_i,
    input wire logic supply_reset_i,
    output logic supply_reset_o,
    output logic supply_reset_oe_n_o,
    input wire logic monitor2_indicator_i,
    output logic monitor2_indicator_o,
    output logic monitor2_indicator_oe_n_o,
    input wire logic monitor3_indicator_i,
    output logic monitor3_indicator_o,
    output logic monitor3_indicator_oe_n_o
);
    import srs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic supply_ok_s1_reg;
    logic supply_ok_s2_reg;
    logic mr_s1_reg;
    logic mr_s2_reg;
    logic mon2_s1_reg;
    logic mon2_s2_reg;
    logic mon3_s1_reg;
    logic mon3_s2_reg;
    srs_state_t state_reg;
    srs_state_t state_next;
    srs_cnt_t cnt_reg;
    srs_cnt_t cnt_next;
    logic reset_active_reg;
    logic reset_active_next;
    logic mon2_release_reg;
    logic mon3_release_reg;
    logic pin_low_reg;
    logic [1:0] hold_sel;
    logic reset_cause;
    logic cnt_expired;

    // delay-select code to hold length in cycles
    function automatic srs_cnt_t hold_cycles(input logic [1:0] sel);
        srs_cnt_t cyc;
        unique case (sel)
            SRS_SEL_0: cyc = HOLD_CYC_0;
            SRS_SEL_1: cyc = HOLD_CYC_1;
            SRS_SEL_2: cyc = HOLD_CYC_2;
            default: cyc = HOLD_CYC_3;
        endcase
        return cyc;
    endfunction : hold_cycles

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers, two flops each

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            supply_ok_s1_reg <= SRS_SYNC_RST;
            supply_ok_s2_reg <= SRS_SYNC_RST;
            mr_s1_reg <= SRS_SYNC_RST;
            mr_s2_reg <= SRS_SYNC_RST;
        end else begin
            supply_ok_s1_reg <= supply_ok_i;
            supply_ok_s2_reg <= supply_ok_s1_reg;
            mr_s1_reg <= manual_reset_request_i;
            mr_s2_reg <= mr_s1_reg;
        end
    end

    // monitor comparator synchronisers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mon2_s1_reg <= SRS_SYNC_RST;
            mon2_s2_reg <= SRS_SYNC_RST;
            mon3_s1_reg <= SRS_SYNC_RST;
            mon3_s2_reg <= SRS_SYNC_RST;
        end else begin
            mon2_s1_reg <= monitor2_input_i;
            mon2_s2_reg <= mon2_s1_reg;
            mon3_s1_reg <= monitor3_input_i;
            mon3_s2_reg <= mon3_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset cause and hold selection

    assign hold_sel = {hold_select_msb_i, hold_select_lsb_i};
    assign reset_cause = !supply_ok_s2_reg || mr_s2_reg;
    assign cnt_expired = (cnt_reg == SRS_CNT_LAST);

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            SRS_ST_ACTIVE: begin
                cnt_next = hold_cycles(hold_sel);
                if (!reset_cause) begin
                    state_next = SRS_ST_HOLD;
                end
            end
            SRS_ST_HOLD: begin
                if (reset_cause) begin
                    state_next = SRS_ST_ACTIVE;
                    cnt_next = hold_cycles(hold_sel);
                end else if (cnt_expired) begin
                    state_next = SRS_ST_RUN;
                end else begin
                    cnt_next = cnt_reg - SRS_CNT_LAST;
                end
            end
            SRS_ST_RUN: begin
                if (reset_cause) begin
                    state_next = SRS_ST_ACTIVE;
                    cnt_next = hold_cycles(hold_sel);
                end
            end
            default: begin
                state_next = SRS_ST_ACTIVE;
                cnt_next = hold_cycles(hold_sel);
            end
        endcase
    end

    // reset is active in every state but run
    assign reset_active_next = (state_next != SRS_ST_RUN);

    // sequencer registers; power-on enters the active state
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= SRS_ST_ACTIVE;
            cnt_reg <= SRS_CNT_RST;
            reset_active_reg <= SRS_RESET_ACTIVE_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            reset_active_reg <= reset_active_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // open-drain pins: data always low, enable released for a high level

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mon2_release_reg <= SRS_MON_RELEASE_RST;
            mon3_release_reg <= SRS_MON_RELEASE_RST;
            pin_low_reg <= SRS_PIN_LOW_RST;
        end else begin
            mon2_release_reg <= mon2_s2_reg;
            mon3_release_reg <= mon3_s2_reg;
            pin_low_reg <= SRS_PIN_LOW_RST;
        end
    end

    // pin inputs are not needed; the pad level equals what is driven
    assign supply_reset_o = pin_low_reg;
    assign supply_reset_oe_n_o = reset_active_reg;
    assign monitor2_indicator_o = pin_low_reg;
    assign monitor2_indicator_oe_n_o = mon2_release_reg;
    assign monitor3_indicator_o = pin_low_reg;
    assign monitor3_indicator_oe_n_o = mon3_release_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // low supply drives reset active next cycle
    property p_supply_low;
        !supply_ok_s2_reg |=> supply_reset_oe_n_o;
    endproperty
    a_supply_low: assert property (p_supply_low)
        else $error("reset not active during low supply");

    // hold state always shows reset active
    property p_hold_active;
        state_reg == SRS_ST_HOLD |-> supply_reset_oe_n_o;
    endproperty
    a_hold_active: assert property (p_hold_active)
        else $error("reset released during hold");

    // hold count taken from select on entry
    property p_hold_load;
        (state_reg == SRS_ST_HOLD) && ($past(state_reg) == SRS_ST_ACTIVE)
            |-> cnt_reg == hold_cycles($past(hold_sel));
    endproperty
    a_hold_load: assert property (p_hold_load)
        else $error("hold count does not match select");

    // manual request forces reset
    property p_manual;
        mr_s2_reg |=> supply_reset_oe_n_o && (state_reg == SRS_ST_ACTIVE);
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual request did not force reset");

    // release only at hold expiry
    property p_release;
        $fell(supply_reset_oe_n_o) |-> $past(state_reg) == SRS_ST_HOLD
            && $past(cnt_reg) == SRS_CNT_LAST && !$past(reset_cause);
    endproperty
    a_release: assert property (p_release)
        else $error("reset released before hold expiry");

    // monitor3 indicator high follows comparator high one cycle later
    property p_mon3;
        mon3_s2_reg |=> monitor3_indicator_oe_n_o;
    endproperty
    a_mon3: assert property (p_mon3)
        else $error("monitor3 indicator wrong");

    // monitor2 indicator low follows comparator low
    property p_mon2;
        !mon2_s2_reg ##1 !mon2_s2_reg |-> !monitor2_indicator_oe_n_o;
    endproperty
    a_mon2: assert property (p_mon2)
        else $error("monitor2 indicator wrong");

    // counter steps down by one while holding
    property p_count;
        (state_reg == SRS_ST_HOLD) && !reset_cause && !cnt_expired
            |=> (state_reg == SRS_ST_HOLD) && (cnt_reg == $past(cnt_reg) - SRS_CNT_LAST);
    endproperty
    a_count: assert property (p_count)
        else $error("hold counter did not step");

    // any cause during hold restarts
    property p_restart;
        (state_reg == SRS_ST_HOLD) && reset_cause |=> state_reg == SRS_ST_ACTIVE;
    endproperty
    a_restart: assert property (p_restart)
        else $error("hold not restarted by cause");

    // covers of the main sequences
    c_release: cover property ($fell(supply_reset_oe_n_o));
    c_manual: cover property ($rose(mr_s2_reg) && state_reg == SRS_ST_RUN);
    c_restart: cover property ((state_reg == SRS_ST_HOLD) && reset_cause);
    c_mon2: cover property ($rose(monitor2_indicator_oe_n_o));

endmodule : srs_supervisor

// ==== tb_top.sv ====
// self-checking bench of the supply reset supervisor
`timescale 1ns/10ps
module tb_top;
    import srs_pkg::*;
    typedef struct {logic m2; logic m3; logic e2; logic e3;} srs_row_t;
    int hold_n [4] = '{4, 6, 8, 10};
    srs_row_t rows [5] = '{'{0, 0, 0, 0}, '{1, 0, 1, 0}, '{0, 1, 0, 1}, '{1, 1, 1, 1}, '{0, 0, 0, 0}};
    logic core_clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic supply_ok_i = 1'h1;
    logic req_en = 1'h0;
    logic req_val = 1'h0;
    logic mon2 = 1'h0;
    logic mon3 = 1'h0;
    logic [1:0] sel = 2'h0;
    logic req_w, rst_w, m2_w, m3_w, rst_d, rst_oe, m2_d, m2_oe, m3_d, m3_oe;
    int fail_count = 0;
    int num_checks = 0;
    int n;

    // free-running core clock
    always #12.5 core_clk_i = ~core_clk_i;

    srs_supervisor #(.HOLD_CYC_0(20'h4), .HOLD_CYC_1(20'h6), .HOLD_CYC_2(20'h8),
        .HOLD_CYC_3(20'ha)) i_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .supply_ok_i(supply_ok_i),
        .manual_reset_request_i(req_w), .monitor2_input_i(mon2), .monitor3_input_i(mon3),
        .hold_select_lsb_i(sel[0]), .hold_select_msb_i(sel[1]), .supply_reset_i(rst_w),
        .supply_reset_o(rst_d), .supply_reset_oe_n_o(rst_oe), .monitor2_indicator_i(m2_w),
        .monitor2_indicator_o(m2_d), .monitor2_indicator_oe_n_o(m2_oe),
        .monitor3_indicator_i(m3_w), .monitor3_indicator_o(m3_d),
        .monitor3_indicator_oe_n_o(m3_oe));

    srs_pin_model i_pins (
        .rst_oe_n_i(rst_oe), .rst_data_i(rst_d), .m2_oe_n_i(m2_oe), .m2_data_i(m2_d),
        .m3_oe_n_i(m3_oe), .m3_data_i(m3_d), .req_en_i(req_en), .req_val_i(req_val),
        .rst_wire_o(rst_w), .m2_wire_o(m2_w), .m3_wire_o(m3_w), .req_wire_o(req_w));

    ////////////////////////////////////////////////////////////////////////////////
    // compare, timing and report tasks
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_cnt(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic step(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask : step

    // edges until the reset wire reaches the level, bounded
    task automatic meas(input logic lvl, output int c);
        c = 0;
        while (rst_w !== lvl && c < 400) begin
            step(1);
            c++;
        end
        if (c >= 400) begin
            fail_count++;
            results();
        end
    endtask : meas

    task automatic req(input logic v);
        req_en = v;
        req_val = v;
    endtask : req

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge core_clk_i);
        #1;
        chk_bit(rst_w, 1'h1);
        chk_bit(m2_w, 1'h0);
        rst_n_i = 1'h1;
        // two sync edges, one edge into hold, then the hold count itself
        meas(1'h0, n);
        chk_cnt(n, 3 + hold_n[0]);
        done("power_up");
        // monitor rows: old level two edges on, new level on the third
        for (int i = 1; i < 5; i++) begin
            mon2 = rows[i].m2;
            mon3 = rows[i].m3;
            step(2);
            chk_bit(m2_w, rows[i-1].e2);
            chk_bit(m3_w, rows[i-1].e3);
            step(1);
            chk_bit(m2_w, rows[i].e2);
            chk_bit(m3_w, rows[i].e3);
        end
        done("monitors");
        // manual request with every hold code
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            req(1'h1);
            step(2);
            chk_bit(rst_w, 1'h0);
            step(1);
            chk_bit(rst_w, 1'h1);
            step(3);
            req(1'h0);
            meas(1'h0, n);
            chk_cnt(n, 3 + hold_n[s]);
        end
        done("manual_hold");
        // one-cycle request in mid-hold restarts the full count
        sel = 2'h1;
        req(1'h1);
        step(5);
        req(1'h0);
        step(3);
        req(1'h1);
        step(1);
        req(1'h0);
        meas(1'h0, n);
        chk_cnt(n, 3 + hold_n[1]);
        done("restart");
        // supply dip
        supply_ok_i = 1'h0;
        step(2);
        chk_bit(rst_w, 1'h0);
        step(1);
        chk_bit(rst_w, 1'h1);
        step(4);
        supply_ok_i = 1'h1;
        meas(1'h0, n);
        chk_cnt(n, 3 + hold_n[1]);
        done("supply_low");
        // select changed during hold only affects later cycles
        sel = 2'h3;
        req(1'h1);
        step(4);
        req(1'h0);
        step(4);
        sel = 2'h0;
        meas(1'h0, n);
        chk_cnt(n + 4, 3 + hold_n[3]);
        done("select_change");
        // second reset in mid-run
        mon2 = 1'h1;
        step(4);
        rst_n_i = 1'h0;
        step(1);
        chk_bit(rst_w, 1'h1);
        chk_bit(m2_w, 1'h0);
        rst_n_i = 1'h1;
        meas(1'h0, n);
        chk_cnt(n, 3 + hold_n[0]);
        done("second_reset");
        results();
    end
endmodule : tb_top
